// ---- adc_serial_read_port_test.sv ----
`default_nettype none

module adc_serial_read_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        sel = 1'b0;
  logic        wt = 1'b0;
  logic        l16 = 1'b0;
  logic        rv = 1'b0;
  logic        lost;
  logic        lst;
  logic        busy;
  logic        rdn;
  logic        wdn;
  logic [23:0] wd = 24'h000000;
  logic [23:0] rin = 24'h000000;
  logic [23:0] rdat;
  logic [23:0] ctrl;
  logic [23:0] a;
  logic [23:0] b;
  int          bad_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          nr = 0;
  int          nw = 1;
  int          dr = 0;
  int          dw = 0;

  adcsp_if lnk ();
  always #4 clk = ~clk;

  adcsp_device adcsp_device_inst (.sys_clk_in(clk), .rst_in(rst), .link(lnk.device), .result_in(rin),
    .result_valid_in(rv), .ctrl_out(ctrl), .result_lost_out(lost));
  adcsp_host adcsp_host_inst (.sys_clk_in(clk), .rst_in(rst), .link(lnk.host), .rd_req_in(rd),
    .wr_req_in(wr), .sel_in(sel), .wait_rdy_in(wt), .len16_in(l16), .wr_data_in(wd),
    .rd_data_out(rdat), .rd_done_out(rdn), .wr_done_out(wdn), .busy_out(busy));
  adcsp_assertions adcsp_assertions_inst (.sys_clk_in(clk), .rst_in(rst), .mode_sel(lnk.mode_sel),
    .read_frame_n(lnk.read_frame_n), .write_frame_n(lnk.write_frame_n),
    .register_select(lnk.register_select), .data_ready_n(lnk.data_ready_n), .dev_data(lnk.dev_data),
    .dev_data_oe(lnk.dev_data_oe), .sclk_drv(lnk.sclk_drv), .sclk_oe(lnk.sclk_oe));

  // ------
  // Helpers
  // ------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Short words keep only the top 16 bits
  function automatic logic [23:0] ex(input logic [23:0] w, input logic l);
    ex = l ? {8'h00, w[23:8]} : w;
  endfunction : ex

  task automatic go(input logic r, input logic s, input logic w, input logic l, input logic [23:0] d);
    rd = r;
    wr = ~r;
    sel = s;
    wt = w;
    l16 = l;
    wd = d;
    if (r)
      nr++;
    else
      nw++;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    while (busy !== 1'b0) @(negedge clk);
  endtask : go

  task automatic rdchk(input logic s, input logic w, input logic l, input logic [23:0] e);
    go(1'b1, s, w, l, 24'h000000);
    chk(l ? {8'h00, rdat[15:0]} : rdat, ex(e, l));
  endtask : rdchk

  task automatic put(input logic [23:0] d);
    rin = d;
    rv = 1'b1;
    @(negedge clk);
    rv = 1'b0;
    lst = lost;
    @(negedge clk);
  endtask : put

  task automatic fl(input logic e);
    chk({23'h0, lnk.data_ready_n}, {23'h0, e});
  endtask : fl

  // Done pulses, counted mid-cycle to avoid the launch edge
  always @(negedge clk) begin
    dr += int'(rdn === 1'b1);
    dw += int'(wdn === 1'b1);
  end

  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end

  // ------
  // Sequence
  // ------
  initial begin
    void'($urandom(10489));
    repeat (8) @(negedge clk);
    chk(ctrl, adcsp_pkg::CTRL_RESET);
    rst = 1'b0;
    @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
    chk(ctrl, adcsp_pkg::CAL_CMD_WORD);
    rdchk(1'b0, 1'b0, 1'b0, adcsp_pkg::CAL_CMD_WORD);
    $display("test boot done");
    for (int i = 0; i < 4; i++) begin
      a = i == 0 ? 24'hffffff : (i == 1 ? 24'h000000 : 24'($urandom));
      put(a);
      fl(1'b0);
      rdchk(1'b1, 1'b1, 1'b0, a);
      fl(1'b1);
    end
    b = ~a;
    put(a);
    put(b);
    rdchk(1'b1, 1'b1, 1'b0, b);
    put(a);
    rdchk(1'b0, 1'b0, 1'b0, adcsp_pkg::CAL_CMD_WORD);
    fl(1'b0);
    rdchk(1'b1, 1'b1, 1'b0, a);
    $display("test output done");
    b = ~a;
    put(a);
    rd = 1'b1;
    nr++;
    @(negedge clk);
    rd = 1'b0;
    repeat (40) @(negedge clk);
    put(b);
    while (busy !== 1'b0) @(negedge clk);
    chk(rdat, a);
    chk({23'h0, lst}, 24'h000001);
    fl(1'b1);
    $display("test overlap done");
    a = {21'($urandom), 3'h1};
    go(1'b0, 1'b0, 1'b0, 1'b0, a);
    chk(ctrl, a);
    rdchk(1'b0, 1'b0, 1'b0, a);
    b = 24'($urandom);
    put(b);
    rdchk(1'b1, 1'b1, 1'b1, b);
    fl(1'b1);
    for (int k = 0; k < 2; k++) begin
      put(a);
      go(1'b0, 1'b0, 1'b0, 1'b0, {21'h0, k[0], 2'h2});
      rdchk(1'b1, 1'b0, 1'b0, k == 1 ? adcsp_pkg::CAL_FULL_RESET : adcsp_pkg::CAL_ZERO_RESET);
      b = 24'($urandom);
      go(1'b0, 1'b1, 1'b0, 1'b0, b);
      rdchk(1'b1, 1'b0, 1'b0, b);
      fl(1'b0);
    end
    chk(24'(dr), 24'(nr));
    chk(24'(dw), 24'(nw));
    $display("test write done");
    finish_test();
  end
endmodule : adc_serial_read_port_test

`default_nettype wire

// ---- adcsp_assertions.sv ----
`default_nettype none

module adcsp_assertions (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic mode_sel,
  input wire logic read_frame_n,
  input wire logic write_frame_n,
  input wire logic register_select,
  input wire logic data_ready_n,
  input wire logic dev_data,
  input wire logic dev_data_oe,
  input wire logic sclk_drv,
  input wire logic sclk_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Bit counter
  // ------
  logic [4:0] n_q;
  logic [4:0] n_d;
  logic       p_q;
  logic       p_d;

  always_comb begin
    p_d = sclk_drv;
    n_d = sclk_oe ? n_q + {4'h0, sclk_drv & ~p_q} : 5'h00;
  end

  always_ff @(posedge sys_clk_in) begin
    n_q <= rst_in ? 5'h00 : n_d;
    p_q <= p_d;
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  AST_CLK_IN_FRAME: assert property ($rose(sclk_oe) |-> mode_sel && !(read_frame_n && write_frame_n))
    else $error("shift clock outside a frame");
  AST_MSB_AT_START: assert property ($rose(dev_data_oe) |-> sclk_oe && !sclk_drv)
    else $error("read start without low clock");
  AST_DATA_ON_FALL: assert property (dev_data_oe && $past(dev_data_oe) && $changed(dev_data) |-> $fell(sclk_drv))
    else $error("data moved off a falling edge");
  AST_STOP_CLEAN: assert property ($fell(sclk_oe) |-> !dev_data_oe && $past(sclk_drv))
    else $error("bad stop");
  AST_WORD_LEN: assert property ($fell(sclk_oe) |-> n_q == 5'h18 || (n_q == 5'h10 && register_select && write_frame_n))
    else $error("wrong bit count");
  AST_FLAG_ON_STOP: assert property ($rose(data_ready_n) |-> $fell(sclk_oe) && register_select && write_frame_n)
    else $error("flag rose off an output stop");
  AST_FLAG_KEPT: assert property (!read_frame_n && !register_select |-> !$rose(data_ready_n))
    else $error("control read moved flag");
  AST_SEL_STEADY: assert property (!read_frame_n && !$past(read_frame_n) |-> $stable(register_select))
    else $error("select moved in frame");
  AST_IDLE_RELEASED: assert property ((read_frame_n && write_frame_n) [*6] |-> !sclk_oe && !dev_data_oe)
    else $error("lines driven while idle");

  cover property ($fell(sclk_oe) && n_q == 5'h10);
  cover property ($fell(sclk_oe) && !write_frame_n);
  cover property ($rose(data_ready_n));
endmodule : adcsp_assertions

`default_nettype wire

// ---- adcsp_device.sv ----
`default_nettype none

module adcsp_device #(
  parameter int HALF_CYC = adcsp_pkg::SCLK_HALF_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  adcsp_if.device          link,
  input  wire logic [23:0] result_in,
  input  wire logic        result_valid_in,
  output logic      [23:0] ctrl_out,
  output logic             result_lost_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s;
  logic       rfs_s;
  logic       tfs_s;
  logic       sel_s;
  logic       mode_s;
  logic       sdl_s;

  adcsp_sync #(
    .W       (5),
    .RST_VAL (adcsp_pkg::DEV_SYNC_RST)
  ) u_pin_sync (
    .clk_in (sys_clk_in),
    .rst_in (rst_in),
    .d_in   ({link.read_frame_n, link.write_frame_n, link.register_select,
              link.mode_sel, link.serial_data_line}),
    .q_out  (pin_s)
  );

  assign rfs_s  = pin_s[4];
  assign tfs_s  = pin_s[3];
  assign sel_s  = pin_s[2];
  assign mode_s = pin_s[1];
  assign sdl_s  = pin_s[0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  adcsp_pkg::adcsp_dev_state_e st_q;
  adcsp_pkg::adcsp_dev_state_e st_d;

  logic [adcsp_pkg::HALF_W-1:0] half_q;
  logic [adcsp_pkg::HALF_W-1:0] half_d;
  logic [adcsp_pkg::CNT_W-1:0]  cnt_q;
  logic [adcsp_pkg::CNT_W-1:0]  cnt_d;
  logic [adcsp_pkg::CNT_W-1:0]  len_q;
  logic [adcsp_pkg::CNT_W-1:0]  len_d;
  logic [23:0]                  sh_q;
  logic [23:0]                  sh_d;
  logic [23:0]                  out_reg_q;
  logic [23:0]                  out_reg_d;
  logic [23:0]                  ctrl_q;
  logic [23:0]                  ctrl_d;
  logic [23:0]                  cal_q [2];
  logic [23:0]                  cal_d [2];
  logic                         src_out_q;
  logic                         src_out_d;
  logic                         wsel_q;
  logic                         wsel_d;
  logic                         sclk_q;
  logic                         sclk_d;
  logic                         sclk_oe_q;
  logic                         sclk_oe_d;
  logic                         sdo_oe_q;
  logic                         sdo_oe_d;
  logic                         data_ready_n_n_q;
  logic                         data_ready_n_n_d;
  logic                         lost_q;
  logic                         lost_d;
  logic                         rfs_prev_q;
  logic                         tfs_prev_q;

  logic tick;
  logic frame_hi;
  logic fin;
  logic start_rd;
  logic reading_out;
  logic rfs_fall;
  logic tfs_fall;
  logic wl16;
  logic cal_idx;

  assign tick     = (half_q == adcsp_pkg::HALF_W'(HALF_CYC - 1));
  assign rfs_fall = rfs_prev_q & ~rfs_s;
  assign tfs_fall = tfs_prev_q & ~tfs_s;
  assign wl16     = ctrl_q[adcsp_pkg::CTRL_WL16_BIT];
  assign cal_idx  = ctrl_q[adcsp_pkg::CTRL_CAL_IDX_BIT];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d      = st_q;
    half_d    = half_q;
    cnt_d     = cnt_q;
    len_d     = len_q;
    sh_d      = sh_q;
    out_reg_d = out_reg_q;
    ctrl_d    = ctrl_q;
    cal_d     = cal_q;
    src_out_d = src_out_q;
    wsel_d    = wsel_q;
    sclk_d    = sclk_q;
    sclk_oe_d = sclk_oe_q;
    sdo_oe_d  = sdo_oe_q;
    data_ready_n_n_d  = data_ready_n_n_q;
    lost_d    = 1'b0;
    start_rd  = 1'b0;
    frame_hi  = (st_q == adcsp_pkg::ADCSP_READ) ? rfs_s : tfs_s;
    // Last rising edge seen; stop at the next falling point or when the host lets go early
    fin       = (cnt_q == len_q) && sclk_q && (tick || frame_hi);
    unique case (st_q)
      adcsp_pkg::ADCSP_IDLE: begin
        half_d = '0;
        // [RL1] self clock only
        if (mode_s && rfs_fall) begin
          // [RL2] source by select
          if (sel_s && !ctrl_q[adcsp_pkg::CTRL_CAL_SEL_BIT]) begin
            // [RL9] refuse when empty
            if (!data_ready_n_n_q) begin
              start_rd  = 1'b1;
              src_out_d = 1'b1;
              sh_d      = wl16 ? {out_reg_q[23:8], 8'h00} : out_reg_q;
              len_d     = wl16 ? adcsp_pkg::LEN16 : adcsp_pkg::LEN24;
            end
          end else begin
            // [RL10] no flag check
            start_rd  = 1'b1;
            src_out_d = 1'b0;
            sh_d      = sel_s ? cal_q[cal_idx] : ctrl_q;
            // [RL12] fixed 24 bits
            len_d     = adcsp_pkg::LEN24;
          end
        end else if (mode_s && tfs_fall) begin
          // [RL19] write enables clock
          st_d      = adcsp_pkg::ADCSP_WRITE;
          sclk_oe_d = 1'b1;
          sclk_d    = 1'b0;
          cnt_d     = '0;
          // [RL18] fixed 24 bits
          len_d     = adcsp_pkg::LEN24;
          wsel_d    = sel_s;
        end
        // [RL13] clock on, MSB out
        if (start_rd) begin
          st_d      = adcsp_pkg::ADCSP_READ;
          sclk_oe_d = 1'b1;
          sclk_d    = 1'b0;
          sdo_oe_d  = 1'b1;
          cnt_d     = '0;
        end
      end
      adcsp_pkg::ADCSP_READ, adcsp_pkg::ADCSP_WRITE: begin
        half_d = tick ? '0 : half_q + adcsp_pkg::HALF_W'(1);
        if (fin || frame_hi) begin
          // [RL15] stop after LSB
          st_d      = adcsp_pkg::ADCSP_IDLE;
          // [RL20] release lines
          sclk_oe_d = 1'b0;
          sdo_oe_d  = 1'b0;
          sclk_d    = 1'b1;
          // [RL5] clear on last bit
          // [RL8] output reads only
          if (fin && st_q == adcsp_pkg::ADCSP_READ && src_out_q) begin
            data_ready_n_n_d = 1'b1;
          end
          // [RL18] commit whole word
          if (fin && st_q == adcsp_pkg::ADCSP_WRITE) begin
            if (wsel_q) begin
              cal_d[cal_idx] = sh_q;
            end else begin
              ctrl_d = sh_q;
            end
          end
        end else if (tick) begin
          if (!sclk_q) begin
            sclk_d = 1'b1;
            cnt_d  = cnt_q + adcsp_pkg::CNT_W'(1);
            // [RL19] capture on rising
            if (st_q == adcsp_pkg::ADCSP_WRITE) begin
              sh_d = {sh_q[22:0], sdl_s};
            end
          end else begin
            sclk_d = 1'b0;
            // [RL14] shift on falling
            if (st_q == adcsp_pkg::ADCSP_READ) begin
              sh_d = {sh_q[22:0], 1'b0};
            end
          end
        end
      end
    endcase
    // [RL7] drop during read
    reading_out = (st_q == adcsp_pkg::ADCSP_READ && src_out_q && !fin) || (start_rd && src_out_d);
    if (result_valid_in) begin
      if (reading_out) begin
        lost_d = 1'b1;
      end else begin
        // [RL4] new word, flag low
        // [RL6] overwrite unread word
        out_reg_d = result_in;
        data_ready_n_n_d  = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q       <= adcsp_pkg::ADCSP_IDLE;
      half_q     <= '0;
      cnt_q      <= '0;
      len_q      <= adcsp_pkg::LEN24;
      sh_q       <= 24'h000000;
      out_reg_q  <= 24'h000000;
      // [RL16] control default
      ctrl_q     <= adcsp_pkg::CTRL_RESET;
      cal_q[0]   <= adcsp_pkg::CAL_ZERO_RESET;
      cal_q[1]   <= adcsp_pkg::CAL_FULL_RESET;
      src_out_q  <= 1'b0;
      wsel_q     <= 1'b0;
      sclk_q     <= 1'b1;
      sclk_oe_q  <= 1'b0;
      sdo_oe_q   <= 1'b0;
      data_ready_n_n_q   <= 1'b1;
      lost_q     <= 1'b0;
      rfs_prev_q <= 1'b1;
      tfs_prev_q <= 1'b1;
      ctrl_out   <= adcsp_pkg::CTRL_RESET;
    end else begin
      st_q       <= st_d;
      half_q     <= half_d;
      cnt_q      <= cnt_d;
      len_q      <= len_d;
      sh_q       <= sh_d;
      out_reg_q  <= out_reg_d;
      ctrl_q     <= ctrl_d;
      cal_q      <= cal_d;
      src_out_q  <= src_out_d;
      wsel_q     <= wsel_d;
      sclk_q     <= sclk_d;
      sclk_oe_q  <= sclk_oe_d;
      sdo_oe_q   <= sdo_oe_d;
      data_ready_n_n_q   <= data_ready_n_n_d;
      lost_q     <= lost_d;
      rfs_prev_q <= rfs_s;
      tfs_prev_q <= tfs_s;
      ctrl_out   <= ctrl_d;
    end
  end

  assign result_lost_out   = lost_q;
  assign link.data_ready_n = data_ready_n_n_q;
  assign link.dev_data     = sh_q[23];
  assign link.dev_data_oe  = sdo_oe_q;
  assign link.sclk_drv     = sclk_q;
  assign link.sclk_oe      = sclk_oe_q;

endmodule : adcsp_device

`default_nettype wire

// ---- adcsp_host.sv ----
`default_nettype none

module adcsp_host (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  adcsp_if.host            link,
  input  wire logic        rd_req_in,
  input  wire logic        wr_req_in,
  input  wire logic        sel_in,
  input  wire logic        wait_rdy_in,
  input  wire logic        len16_in,
  input  wire logic [23:0] wr_data_in,
  output logic      [23:0] rd_data_out,
  output logic             rd_done_out,
  output logic             wr_done_out,
  output logic             busy_out
);

  adcsp_pkg::adcsp_host_state_e st_q;
  adcsp_pkg::adcsp_host_state_e st_d;

  logic [adcsp_pkg::CNT_W-1:0] len_q;
  logic [adcsp_pkg::CNT_W-1:0] len_d;
  logic [23:0]                 word_q;
  logic [23:0]                 word_d;
  logic [23:0]                 rd_data_d;
  logic                        sel_q;
  logic                        sel_d;
  logic                        is_rd_q;
  logic                        is_rd_d;
  logic                        rfs_n_q;
  logic                        rfs_n_d;
  logic                        tfs_n_q;
  logic                        tfs_n_d;
  logic                        data_oe_q;
  logic                        data_oe_d;
  logic                        idle_q;
  logic                        rd_done_d;
  logic                        wr_done_d;
  logic [1:0]                  back_s;
  logic                        done_s;
  logic                        data_ready_n_s;

  // Link-side state
  logic [adcsp_pkg::CNT_W-1:0] lcnt_q;
  logic [adcsp_pkg::CNT_W-1:0] lcnt_d;
  logic                        ldone_q;
  logic                        ldone_d;
  logic [23:0]                 rsh_q;
  logic [23:0]                 rsh_d;
  logic                        sdo_q;
  logic                        sdo_d;

  adcsp_sync #(
    .W       (2),
    .RST_VAL (adcsp_pkg::HOST_SYNC_RST)
  ) u_back_sync (
    .clk_in (sys_clk_in),
    .rst_in (rst_in),
    .d_in   ({ldone_q, link.data_ready_n}),
    .q_out  (back_s)
  );

  assign done_s = back_s[1];
  assign data_ready_n_s = back_s[0];

  // ----------------------------------------
  // Request sequencing
  // ----------------------------------------
  always_comb begin
    st_d      = st_q;
    len_d     = len_q;
    word_d    = word_q;
    sel_d     = sel_q;
    is_rd_d   = is_rd_q;
    rfs_n_d   = rfs_n_q;
    tfs_n_d   = tfs_n_q;
    data_oe_d = data_oe_q;
    rd_data_d = rd_data_out;
    rd_done_d = 1'b0;
    wr_done_d = 1'b0;
    unique case (st_q)
      adcsp_pkg::ADCSP_H_BOOT: begin
        // [RL17] calibrate after reset
        sel_d     = 1'b0;
        len_d     = adcsp_pkg::LEN24;
        word_d    = adcsp_pkg::CAL_CMD_WORD;
        is_rd_d   = 1'b0;
        tfs_n_d   = 1'b0;
        data_oe_d = 1'b1;
        st_d      = adcsp_pkg::ADCSP_H_FRAME;
      end
      adcsp_pkg::ADCSP_H_IDLE: begin
        if (rd_req_in) begin
          sel_d   = sel_in;
          is_rd_d = 1'b1;
          // [RL12] 24 unless len16_in, whatever the select
          len_d   = len16_in ? adcsp_pkg::LEN16 : adcsp_pkg::LEN24;
          // [RL11] flag gates any read requested with wait_rdy_in set, whatever the select
          if (wait_rdy_in) begin
            st_d = adcsp_pkg::ADCSP_H_WAIT;
          end else begin
            rfs_n_d = 1'b0;
            st_d    = adcsp_pkg::ADCSP_H_FRAME;
          end
        end else if (wr_req_in) begin
          sel_d     = sel_in;
          is_rd_d   = 1'b0;
          // [RL18] always 24 bits
          len_d     = adcsp_pkg::LEN24;
          word_d    = wr_data_in;
          tfs_n_d   = 1'b0;
          data_oe_d = 1'b1;
          st_d      = adcsp_pkg::ADCSP_H_FRAME;
        end
      end
      adcsp_pkg::ADCSP_H_WAIT: begin
        if (!data_ready_n_s) begin
          rfs_n_d = 1'b0;
          st_d    = adcsp_pkg::ADCSP_H_FRAME;
        end
      end
      adcsp_pkg::ADCSP_H_FRAME: begin
        // [RL3] select held until done
        if (done_s) begin
          rfs_n_d   = 1'b1;
          tfs_n_d   = 1'b1;
          data_oe_d = 1'b0;
          rd_done_d = is_rd_q;
          wr_done_d = ~is_rd_q;
          if (is_rd_q) begin
            rd_data_d = rsh_q;
          end
          st_d = adcsp_pkg::ADCSP_H_REL;
        end
      end
      adcsp_pkg::ADCSP_H_REL: begin
        if (!done_s) begin
          st_d = adcsp_pkg::ADCSP_H_IDLE;
        end
      end
      default: begin
        st_d = adcsp_pkg::ADCSP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q        <= adcsp_pkg::ADCSP_H_BOOT;
      len_q       <= adcsp_pkg::LEN24;
      word_q      <= 24'h000000;
      sel_q       <= 1'b0;
      is_rd_q     <= 1'b0;
      rfs_n_q     <= 1'b1;
      tfs_n_q     <= 1'b1;
      data_oe_q   <= 1'b0;
      idle_q      <= 1'b1;
      rd_data_out <= 24'h000000;
      rd_done_out <= 1'b0;
      wr_done_out <= 1'b0;
      busy_out    <= 1'b1;
    end else begin
      st_q        <= st_d;
      len_q       <= len_d;
      word_q      <= word_d;
      sel_q       <= sel_d;
      is_rd_q     <= is_rd_d;
      rfs_n_q     <= rfs_n_d;
      tfs_n_q     <= tfs_n_d;
      data_oe_q   <= data_oe_d;
      idle_q      <= rfs_n_d & tfs_n_d;
      rd_data_out <= rd_data_d;
      rd_done_out <= rd_done_d;
      wr_done_out <= wr_done_d;
      busy_out    <= (st_d != adcsp_pkg::ADCSP_H_IDLE);
    end
  end

  // ----------------------------------------
  // Link side, cleared by the idle frame level
  // ----------------------------------------
  // Link clock stops between frames, so its state resets from the frame level instead of rst_in
  always_comb begin
    lcnt_d  = lcnt_q + adcsp_pkg::CNT_W'(1);
    ldone_d = ldone_q | (lcnt_d == len_q);
    // [RL14] sample on rising
    rsh_d   = {rsh_q[22:0], link.serial_data_line};
    // [RL19] MSB first on falling
    sdo_d   = (lcnt_q < len_q) ? word_q[adcsp_pkg::MSB_IDX - lcnt_q] : 1'b0;
  end

  always_ff @(posedge link.shift_clock or posedge idle_q) begin
    if (idle_q) begin
      lcnt_q  <= '0;
      ldone_q <= 1'b0;
    end else begin
      lcnt_q  <= lcnt_d;
      ldone_q <= ldone_d;
    end
  end

  always_ff @(posedge link.shift_clock) begin
    rsh_q <= rsh_d;
  end

  always_ff @(negedge link.shift_clock or posedge idle_q) begin
    if (idle_q) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  // [RL1] strap self clocking
  assign link.mode_sel        = 1'b1;
  assign link.read_frame_n    = rfs_n_q;
  assign link.write_frame_n   = tfs_n_q;
  assign link.register_select = sel_q;
  assign link.host_data       = sdo_q;
  assign link.host_data_oe    = data_oe_q;

endmodule : adcsp_host

`default_nettype wire

// ---- adcsp_if.sv ----
`default_nettype none

interface adcsp_if;

  logic mode_sel;
  logic read_frame_n;
  logic write_frame_n;
  logic register_select;
  logic data_ready_n;
  logic dev_data;
  logic dev_data_oe;
  logic host_data;
  logic host_data_oe;
  logic sclk_drv;
  logic sclk_oe;
  logic serial_data_line;
  logic shift_clock;

  // ----------------------------------------
  // Wire resolution, pull-ups on both lines
  // ----------------------------------------
  assign serial_data_line = dev_data_oe ? dev_data : (host_data_oe ? host_data : 1'b1);
  assign shift_clock      = sclk_oe ? sclk_drv : 1'b1;

  modport device (
    input  mode_sel,
    input  read_frame_n,
    input  write_frame_n,
    input  register_select,
    input  serial_data_line,
    output data_ready_n,
    output dev_data,
    output dev_data_oe,
    output sclk_drv,
    output sclk_oe
  );

  modport host (
    output mode_sel,
    output read_frame_n,
    output write_frame_n,
    output register_select,
    output host_data,
    output host_data_oe,
    input  data_ready_n,
    input  serial_data_line,
    input  shift_clock
  );

endinterface : adcsp_if

`default_nettype wire

// ---- adcsp_pkg.sv ----
// Function
// [RL1] Strap high: converter drives the shift clock
// [RL2] Select high: output/calibration, low: control
// [RL3] Host holds select steady through each read
// [RL4] New result pulls ready flag low
// [RL5] Last output bit returns ready flag high
// [RL6] Unread words keep updating, flag stays low
// [RL7] Result arriving during output read is dropped
// [RL8] Control/calibration reads leave ready flag alone
// [RL9] Output read refused while ready flag high
// [RL10] Control/calibration reads ignore the ready flag
// [RL11] Host ignores ready flag on such reads (the host here waits on the flag for any read with wait_rdy_in set)
// [RL12] Control/calibration reads move exactly 24 bits (the host here reads 16 bits whenever len16_in is set, whatever the select)
// [RL13] Frame fall starts clock, MSB presented at once
// [RL14] Bits change on falling, sampled on rising
// [RL15] LSB on last falling, stop at next
// [RL16] Reset loads control register default
// [RL17] Host issues calibration command after reset
// [RL18] Writes move 24 bits, ready flag untouched
// [RL19] Write frame enables clock, MSB first, rising capture
// [RL20] Data and clock released outside frames
`default_nettype none

package adcsp_pkg;

  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int          WORD_W    = 24;
  localparam int          CNT_W     = 5;
  localparam logic [4:0]  LEN24     = 5'h18;
  localparam logic [4:0]  LEN16     = 5'h10;
  localparam logic [4:0]  MSB_IDX   = 5'h17;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int          CTRL_WL16_BIT    = 0;
  localparam int          CTRL_CAL_SEL_BIT = 1;
  localparam int          CTRL_CAL_IDX_BIT = 2;
  localparam logic [23:0] CTRL_RESET       = 24'h000000;
  localparam logic [23:0] CAL_ZERO_RESET   = 24'h000000;
  localparam logic [23:0] CAL_FULL_RESET   = 24'h800000;
  // Word the host writes after reset to start a calibration
  localparam logic [23:0] CAL_CMD_WORD     = 24'h200000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SYS_PERIOD_NS  = 8;
  localparam int SCLK_PERIOD_NS = 64;
  // Half period rounded up; at least four cycles so the write data survives the synchroniser
  localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int HALF_W         = 4;

  // ----------------------------------------
  // Synchroniser reset levels
  // ----------------------------------------
  // Order: read frame, write frame, select, mode, data
  localparam logic [4:0] DEV_SYNC_RST  = 5'h18;
  // Order: done, ready
  localparam logic [1:0] HOST_SYNC_RST = 2'h1;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [1:0] {
    ADCSP_IDLE,
    ADCSP_READ,
    ADCSP_WRITE
  } adcsp_dev_state_e;

  typedef enum logic [2:0] {
    ADCSP_H_BOOT,
    ADCSP_H_IDLE,
    ADCSP_H_WAIT,
    ADCSP_H_FRAME,
    ADCSP_H_REL
  } adcsp_host_state_e;

endpackage : adcsp_pkg

`default_nettype wire

// ---- adcsp_sync.sv ----
`default_nettype none

module adcsp_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d_in;
    q_d    = meta_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      q_out  <= q_d;
    end
  end

endmodule : adcsp_sync

`default_nettype wire
